// ### rtl/rpd_top.sv
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
module rpd_top
	import rpd_pkg::*;
(
	input  wire logic        pclk,            // 20 MHz clock
	input  wire logic        presetn,         // async reset, low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb write
	input  wire logic [7:0]  paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // unmapped address
	input  wire logic        cmd_valid,       // valid command word
	input  wire logic [15:0] cmd_word,        // bit time 4 at msb
	input  wire logic        rx_word_valid,   // received data word
	input  wire logic [15:0] rx_word,         // received data
	input  wire logic        msg_end,         // last word passed
	input  wire logic        tx_word_req,     // encoder wants a word
	output logic      [15:0] tx_word,         // word to transmit
	output logic             tx_word_valid,   // tx_word is new
	output logic             dma_request_out, // memory request
	input  wire logic        dma_grant_in,    // access done now
	output logic      [15:0] mem_addr,        // memory address
	output logic      [15:0] mem_wdata,       // memory write data
	output logic             mem_we,          // write when high
	input  wire logic [15:0] mem_rdata        // read data at grant
);

	typedef struct packed {
		rpd_state_e  state;
		logic [15:0] bpr;
		logic [1:0]  cfg;
		logic        framing;
		logic [15:0] time_tag;
		logic [4:0]  tick;
		logic [15:0] cmd;
		logic [5:0]  idx;
		logic        mode_data;
		logic        skip_cmd;
		logic        plain_mode;
		logic        hold_v;
		logic [15:0] hold;
		logic        req;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        we;
		logic [15:0] tx_word;
		logic        tx_valid;
		logic [31:0] prdata;
	} rpd_top_s;

	rpd_top_s    r_r;
	rpd_top_s    r_nxt;
	rpd_cnt_if   ci ();
	logic        done;
	logic        tr_bit;
	logic [4:0]  sa_f;
	logic [4:0]  mc_f;
	logic        is_mode;
	logic        wr_acc;
	logic        rd_setup;
	logic        mapped;
	logic [15:0] pb_base;

	// ********************************************************
	// counter and helper decode
	// ********************************************************
	rpd_ptr_counter u_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.ci      (ci.cnt)
	);

	assign done     = r_r.req && dma_grant_in;
	assign tr_bit   = cmd_word[CW_TR_BIT];
	assign sa_f     = cmd_word[CW_SA_LSB +: 5];
	assign mc_f     = cmd_word[4:0];
	assign is_mode  = (sa_f == SA_MODE_LO) || (sa_f == SA_MODE_HI);
	assign pb_base  = {r_r.bpr[15:BPR_BASE_LSB], 6'h00};
	assign ci.size_exp = r_r.bpr[3:0];
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign mapped   = (paddr == OFS_BASE_PTR) || (paddr == OFS_CONFIG)
	               || (paddr == OFS_STATUS) || (paddr == OFS_TIME_TAG)
	               || (paddr == OFS_COUNTER);

	// zero wait states: data is fetched in the setup phase
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && !mapped;
	assign prdata          = r_r.prdata;
	assign tx_word         = r_r.tx_word;
	assign tx_word_valid   = r_r.tx_valid;
	assign dma_request_out = r_r.req;
	assign mem_addr        = r_r.addr;
	assign mem_wdata       = r_r.wdata;
	assign mem_we          = r_r.we;

	// ********************************************************
	// next state
	// ********************************************************
	always_comb begin
		r_nxt        = r_r;
		r_nxt.tx_valid = 1'b0;
		ci.load      = 1'b0;
		ci.inc       = 1'b0;
		ci.load_val  = mem_rdata;

		// time tag runs in microsecond steps
		if (r_r.tick == 5'(TT_TICK_CYC - 1)) begin
			r_nxt.tick     = 5'h00;
			r_nxt.time_tag = r_r.time_tag + 16'h0001;
		end else begin
			r_nxt.tick = r_r.tick + 5'h01;
		end

		if (done) begin
			r_nxt.req = 1'b0;
		end

		case (r_r.state)
		ST_IDLE: begin
			if (cmd_valid && r_r.cfg[CFG_ENABLE]) begin
				r_nxt.cmd        = cmd_word;
				r_nxt.mode_data  = is_mode && mc_f[MC_DATA_BIT];
				r_nxt.plain_mode = is_mode && !mc_f[MC_DATA_BIT];
				r_nxt.skip_cmd   = r_r.cfg[CFG_REV_B] && is_mode
				                 && (mc_f == MC_TX_LAST);
				r_nxt.hold_v     = 1'b0;
				r_nxt.idx        = {tr_bit, sa_f};
				if (is_mode && mc_f[MC_DATA_BIT]) begin
					r_nxt.idx = ENT_MODE_DATA;
				end else if (!tr_bit && r_r.bpr[BPR_MODE_BIT]) begin
					r_nxt.idx = ENT_SINGLE;
				end
				// revision A drops mode with data
				if (is_mode && mc_f[MC_DATA_BIT]
				    && !r_r.cfg[CFG_REV_B]) begin
					r_nxt.state = ST_IDLE;
				end else if (is_mode && !mc_f[MC_DATA_BIT]) begin
					r_nxt.state = ST_CMD;
				end else begin
					r_nxt.state = ST_FETCH;
				end
			end
		end
		ST_FETCH: begin
			if (!r_r.req) begin
				r_nxt.req  = 1'b1;
				r_nxt.we   = 1'b0;
				r_nxt.addr = pb_base | {10'h000, r_r.idx};
			end else if (done) begin
				ci.load = 1'b1;
				if (r_r.mode_data) begin
					// pointer high bits, mode code low
					ci.load_val = {mem_rdata[15:4], r_r.cmd[3:0]};
				end
				if (!r_r.skip_cmd) begin
					r_nxt.state = ST_CMD;
				end else if (r_r.cmd[CW_TR_BIT]) begin
					r_nxt.state = ST_TX_RD;
				end else begin
					r_nxt.state = ST_RX_WAIT;
				end
			end
		end
		ST_CMD: begin
			if (!r_r.req) begin
				r_nxt.req   = 1'b1;
				r_nxt.we    = 1'b1;
				r_nxt.addr  = pb_base | {10'h000, ENT_COMMAND};
				r_nxt.wdata = r_r.cmd;
			end else if (done) begin
				if (r_r.plain_mode) begin
					r_nxt.state = ST_IDLE;
				end else if (r_r.mode_data) begin
					r_nxt.state = r_r.cmd[CW_TR_BIT] ? ST_TX_RD
					                                  : ST_RX_WAIT;
				end else if (r_r.cmd[CW_TR_BIT]) begin
					r_nxt.state = ST_TX_WAIT;
				end else begin
					r_nxt.state = ST_ID;
				end
			end
		end
		ST_ID: begin
			if (!r_r.req) begin
				r_nxt.req   = 1'b1;
				r_nxt.we    = 1'b1;
				r_nxt.addr  = ci.value;
				r_nxt.wdata = r_r.cmd;
			end else if (done) begin
				ci.inc      = 1'b1;
				r_nxt.state = ST_RX_WAIT;
			end
		end
		ST_RX_WAIT: begin
			if (r_r.hold_v) begin
				r_nxt.state = ST_RX_WR;
			end else if (msg_end) begin
				r_nxt.state = r_r.mode_data ? ST_IDLE : ST_TAG;
			end
		end
		ST_RX_WR: begin
			if (!r_r.req) begin
				r_nxt.req   = 1'b1;
				r_nxt.we    = 1'b1;
				r_nxt.addr  = ci.value;
				r_nxt.wdata = r_r.hold;
			end else if (done) begin
				ci.inc       = !r_r.mode_data;
				r_nxt.hold_v = 1'b0;
				r_nxt.state  = r_r.mode_data ? ST_IDLE : ST_RX_WAIT;
			end
		end
		ST_TAG: begin
			if (!r_r.req) begin
				r_nxt.req   = 1'b1;
				r_nxt.we    = 1'b1;
				r_nxt.addr  = ci.value;
				r_nxt.wdata = r_r.time_tag;
			end else if (done) begin
				ci.inc      = 1'b1;
				r_nxt.state = ST_WB;
			end
		end
		ST_WB: begin
			if (!r_r.req) begin
				r_nxt.req   = 1'b1;
				r_nxt.we    = 1'b1;
				r_nxt.addr  = pb_base | {10'h000, r_r.idx};
				r_nxt.wdata = ci.value;
			end else if (done) begin
				r_nxt.state = ST_IDLE;
			end
		end
		ST_TX_WAIT: begin
			if (tx_word_req) begin
				r_nxt.state = ST_TX_RD;
			end else if (msg_end) begin
				r_nxt.state = ST_IDLE;
			end
		end
		ST_TX_RD: begin
			if (!r_r.req) begin
				r_nxt.req  = 1'b1;
				r_nxt.we   = 1'b0;
				r_nxt.addr = ci.value;
			end else if (done) begin
				ci.inc         = !r_r.mode_data;
				r_nxt.tx_word  = mem_rdata;
				r_nxt.tx_valid = 1'b1;
				r_nxt.state    = r_r.mode_data ? ST_IDLE : ST_TX_WAIT;
			end
		end
		default: begin
			r_nxt.state = ST_IDLE;
		end
		endcase

		// a word arriving while the last is unstored is an overrun;
		// late grant stops all accesses
		if (rx_word_valid && r_r.state != ST_IDLE) begin
			if (r_nxt.hold_v) begin
				r_nxt.req    = 1'b0;
				r_nxt.hold_v = 1'b0;
				r_nxt.state  = ST_IDLE;
			end else begin
				r_nxt.hold_v = 1'b1;
				r_nxt.hold   = rx_word;
			end
		end

		// apb writes take effect in the access phase
		if (wr_acc) begin
			if (paddr == OFS_BASE_PTR) begin
				r_nxt.bpr = pwdata[15:0] & BPR_WMASK;
			end else if (paddr == OFS_CONFIG) begin
				r_nxt.cfg = pwdata[1:0];
			end else if (paddr == OFS_STATUS) begin
				r_nxt.framing = r_r.framing & ~pwdata[STS_FRAMING];
			end else if (paddr == OFS_TIME_TAG) begin
				r_nxt.time_tag = pwdata[15:0];
				r_nxt.tick     = 5'h00;
			end
		end

		// overrun flag set wins over a software clear
		if (rx_word_valid && r_r.state != ST_IDLE && r_r.hold_v
		    && !(r_r.state == ST_RX_WR && done)) begin
			r_nxt.framing = 1'b1;
		end

		// read data is captured in the setup phase
		if (rd_setup) begin
			r_nxt.prdata = 32'h0000_0000;
			if (paddr == OFS_BASE_PTR) begin
				r_nxt.prdata = {16'h0000, r_r.bpr};
			end else if (paddr == OFS_CONFIG) begin
				r_nxt.prdata = {30'h0000_0000, r_r.cfg};
			end else if (paddr == OFS_STATUS) begin
				r_nxt.prdata = {30'h0000_0000, r_r.framing,
				                r_r.state != ST_IDLE};
			end else if (paddr == OFS_TIME_TAG) begin
				r_nxt.prdata = {16'h0000, r_r.time_tag};
			end else if (paddr == OFS_COUNTER) begin
				r_nxt.prdata = {16'h0000, ci.value};
			end
		end
	end

	// ********************************************************
	// state register
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r       <= '0;
			r_r.state <= ST_IDLE;
			r_r.bpr   <= BPR_RESET;
			r_r.cfg   <= CFG_RESET;
		end else begin
			r_r <= r_nxt;
		end
	end

endmodule

// ### rtl/rpd_pkg.sv
package rpd_pkg;

	// ********************************************************
	// apb register map (byte offsets)
	// ********************************************************
	localparam logic [7:0]  OFS_BASE_PTR  = 8'h00;
	localparam logic [7:0]  OFS_CONFIG    = 8'h04;
	localparam logic [7:0]  OFS_STATUS    = 8'h08;
	localparam logic [7:0]  OFS_TIME_TAG  = 8'h0C;
	localparam logic [7:0]  OFS_COUNTER   = 8'h10;

	// base_pointer_register fields
	localparam int          BPR_BASE_LSB  = 6;
	localparam int          BPR_MODE_BIT  = 4;
	localparam logic [15:0] BPR_WMASK     = 16'hFFDF;
	localparam logic [15:0] BPR_RESET     = 16'h0003;
	// config fields
	localparam int          CFG_ENABLE    = 0;
	localparam int          CFG_REV_B     = 1;
	localparam logic [1:0]  CFG_RESET     = 2'h0;
	// status fields
	localparam int          STS_ACTIVE    = 0;
	localparam int          STS_FRAMING   = 1;

	// ********************************************************
	// pointer block layout and command word fields
	// ********************************************************
	localparam logic [5:0]  ENT_COMMAND   = 6'h00;
	localparam logic [5:0]  ENT_SINGLE    = 6'h1F;
	localparam logic [5:0]  ENT_MODE_DATA = 6'h20;
	localparam logic [4:0]  SA_MODE_LO    = 5'h00;
	localparam logic [4:0]  SA_MODE_HI    = 5'h1F;
	localparam logic [4:0]  MC_TX_LAST    = 5'h12;
	localparam int          CW_TR_BIT     = 10;
	localparam int          CW_SA_LSB     = 5;
	localparam int          MC_DATA_BIT   = 4;
	localparam logic [3:0]  SIZE_EXP_MIN  = 4'h3;

	// ********************************************************
	// time tag resolution
	// ********************************************************
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          TT_TICK_NS    = 1000;
	localparam int          TT_TICK_CYC   = TT_TICK_NS / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE, ST_FETCH, ST_CMD, ST_ID, ST_RX_WAIT, ST_RX_WR,
		ST_TAG, ST_WB, ST_TX_WAIT, ST_TX_RD
	} rpd_state_e;

endpackage

// ### rtl/rpd_cnt_if.sv
`timescale 1ns/1ns
interface rpd_cnt_if;
	logic        load;     // load start pointer
	logic        inc;      // one memory store or read done
	logic [15:0] load_val; // pointer read from the block
	logic [3:0]  size_exp; // buffer length exponent
	logic [15:0] value;    // current memory address

	modport ctl (output load, inc, load_val, size_exp, input value);
	modport cnt (input load, inc, load_val, size_exp, output value);
endinterface

// ### rtl/rpd_ptr_counter.sv
`timescale 1ns/1ns
module rpd_ptr_counter
	import rpd_pkg::*;
(
	input  wire logic pclk,    // system clock
	input  wire logic presetn, // async reset, active low
	rpd_cnt_if.cnt    ci       // control from sequencer
);

	typedef struct packed {
		logic [15:0] cnt;
	} rpd_cnt_s;

	rpd_cnt_s    cnt_r;
	rpd_cnt_s    cnt_nxt;
	logic [3:0]  exp_eff;
	logic [16:0] mask_w;
	logic [15:0] plus_one;

	// ********************************************************
	// wrapping up-counter
	// ********************************************************
	// exponents below the minimum are raised to it
	// power-of-two lengths
	assign exp_eff  = (ci.size_exp < SIZE_EXP_MIN) ? SIZE_EXP_MIN
	                                                : ci.size_exp;
	assign mask_w   = (17'h0_0001 << exp_eff) - 17'h0_0001;
	assign plus_one = cnt_r.cnt + 16'h0001;
	assign ci.value = cnt_r.cnt;

	// upper bits hold the block boundary, only low bits roll
	always_comb begin
		cnt_nxt = cnt_r;
		if (ci.load) begin
			cnt_nxt.cnt = ci.load_val;
		end else if (ci.inc) begin
			cnt_nxt.cnt = (cnt_r.cnt & ~mask_w[15:0])
			            | (plus_one & mask_w[15:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// ### test/rpd_top_chk.sv
`timescale 1ns/1ns
module rpd_top_chk
	import rpd_pkg::*;
(
	input wire logic        pclk,            // clock
	input wire logic        presetn,         // reset, low
	input wire logic        psel,            // apb select
	input wire logic        penable,         // apb access
	input wire logic        pwrite,          // apb write
	input wire logic [7:0]  paddr,           // apb address
	input wire logic [31:0] pwdata,          // apb data
	input wire logic        pslverr,         // apb error
	input wire logic [15:0] tx_word,         // word out
	input wire logic        tx_word_valid,   // word strobe
	input wire logic        dma_request_out, // request
	input wire logic        dma_grant_in,    // grant
	input wire logic [15:0] mem_addr,        // address
	input wire logic [15:0] mem_wdata,       // write data
	input wire logic        mem_we,          // write
	input wire logic [15:0] mem_rdata        // read data
);
	logic [9:0]  base_r; // mirror of the block base bits
	logic [15:0] rd_r;   // last word read
	logic        blk;

	// *************************************
	// mirrors: base follows apb writes only, so
	// rewriting it mid-message would confuse them
	// *************************************
	assign blk = mem_addr[15:6] == base_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_r <= BPR_RESET[15:6];
			rd_r   <= 16'h0000;
		end else begin
			if (psel && penable && pwrite && paddr == OFS_BASE_PTR)
				base_r <= pwdata[15:6];
			if (dma_request_out && dma_grant_in && !mem_we)
				rd_r <= mem_rdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	req_hold_a: assert property (
		dma_request_out && !dma_grant_in |=> dma_request_out
		&& $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
		else $error("request changed before grant");
	req_gap_a: assert property (
		dma_request_out && dma_grant_in |=> !dma_request_out)
		else $error("request not dropped after grant");
	last_entry_a: assert property (
		dma_request_out && blk |-> mem_addr[5:0] != 6'h3F)
		else $error("last pointer entry accessed");
	no_txwb_a: assert property (
		dma_request_out && mem_we && blk |-> mem_addr[5:0] < 6'h20)
		else $error("write into transmit pointers");
	cmd_noread_a: assert property (
		dma_request_out && !mem_we && blk |-> mem_addr[5:0] != 6'h00)
		else $error("command entry read");
	tx_data_a: assert property (
		tx_word_valid |-> tx_word == rd_r)
		else $error("tx word differs from memory");
	tx_pulse_a: assert property (
		tx_word_valid |=> !tx_word_valid)
		else $error("tx strobe longer than one cycle");
	bad_addr_a: assert property (
		psel && penable && paddr >= 8'h14 |-> pslverr)
		else $error("unmapped address not refused");
endmodule

bind rpd_top rpd_top_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pslverr(pslverr), .tx_word(tx_word),
	.tx_word_valid(tx_word_valid), .dma_request_out(dma_request_out),
	.dma_grant_in(dma_grant_in), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));

// ### test/rpd_mem_model.sv
`timescale 1ns/1ns
module rpd_mem_model (
	input  wire logic        pclk,    // clock
	input  wire logic        presetn, // reset, low
	input  wire logic        req,     // dma request
	input  wire logic        we,      // write
	input  wire logic [15:0] addr,    // address
	input  wire logic [15:0] wdata,   // write data
	input  wire logic [1:0]  lag,     // idle cycles before grant
	output logic             grant,   // one-cycle grant
	output logic      [15:0] rdata    // read data
);
	logic [15:0] mem [0:65535]; // host fills it before enabling
	logic [1:0]  wait_r;

	// grant promptly
	// at most three idle cycles so no rx word is lost; data toggles
	// outside the grant cycle so stale values never look valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grant  <= 1'b0;
			wait_r <= 2'd0;
			rdata  <= 16'h0000;
		end else if (grant) begin
			if (we)
				mem[addr] <= wdata;
			grant <= 1'b0;
			rdata <= ~rdata;
		end else if (req && wait_r >= lag) begin
			grant  <= 1'b1;
			wait_r <= 2'd0;
			rdata  <= mem[addr];
		end else begin
			wait_r <= req ? wait_r + 2'd1 : 2'd0;
			rdata  <= ~rdata;
		end
	end
endmodule

// ### test/tb_rt_pointer_block_buffer_dma.sv
`timescale 1ns/1ns
module tb_rt_pointer_block_buffer_dma;
	import rpd_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        cmd_valid, rx_word_valid, msg_end, tx_word_req;
	logic        tx_word_valid, dma_request_out, dma_grant_in, mem_we;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rq;
	logic [15:0] cmd_word, rx_word, tx_word, mem_addr, mem_wdata;
	logic [15:0] mem_rdata, cw, d, ma;
	logic [1:0]  lag;
	logic [9:0]  base;
	logic [33:0] e;
	logic [33:0] exq [$]; // {check data, write, address, data}
	logic [15:0] txq [$];
	logic [31:0] seed = 32'h8d49_953e;
	int          fail_count, n_compared;

	rpd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.rx_word_valid(rx_word_valid), .rx_word(rx_word),
		.msg_end(msg_end), .tx_word_req(tx_word_req), .tx_word(tx_word),
		.tx_word_valid(tx_word_valid), .dma_request_out(dma_request_out),
		.dma_grant_in(dma_grant_in), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));
	rpd_mem_model mdl (.pclk(pclk), .presetn(presetn),
		.req(dma_request_out), .we(mem_we), .addr(mem_addr),
		.wdata(mem_wdata), .lag(lag), .grant(dma_grant_in),
		.rdata(mem_rdata));

	// *************************************
	// helpers
	// *************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] pb(input logic [5:0] i);
		return {base, i};
	endfunction
	function automatic logic [15:0] nx(input logic [15:0] a,
		input logic [3:0] x);
		logic [15:0] m;
		m = (16'h0001 << x) - 16'h0001;
		return (a & ~m) | ((a + 16'h0001) & m);
	endfunction
	task automatic check(input string nm, input logic [33:0] s,
		input logic [33:0] x);
		n_compared++;
		if (s !== x) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		// a slave that never answers ends the run as a mismatch
		if (pready !== 1'b1) begin
			fail_count++;
			$display("Error apb ready expected 1 seen %b", pready);
			results();
		end
		rq = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		check("register", {2'b00, rq}, {2'b00, x});
	endtask
	task automatic ex(input logic c, input logic w, input logic [15:0] a,
		input logic [15:0] v);
		exq.push_back({c, w, a, v});
	endtask
	// one strobe, then a pause long enough for four accesses
	task automatic send(input int k, input logic [15:0] v);
		cmd_word <= v;
		rx_word <= v;
		cmd_valid <= k == 0;
		rx_word_valid <= k == 1;
		msg_end <= k == 2;
		tx_word_req <= k == 3;
		@(posedge pclk);
		{cmd_valid, rx_word_valid, msg_end, tx_word_req} <= 4'h0;
		repeat (24) @(posedge pclk);
	endtask
	task automatic drain();
		int k;
		for (k = 0; k < 400 && exq.size() + txq.size() > 0; k++)
			@(posedge pclk);
		if (k >= 400) begin
			fail_count++;
			$display("Error drain expected 0 seen %0d", exq.size());
			results();
		end
	endtask
	task automatic rx_msg(input logic [5:0] ent, input logic [4:0] sa,
		input logic [3:0] x, input int n);
		logic [15:0] a;
		a = mdl.mem[pb(ent)];
		cw = {5'h05, 1'b0, sa, n[4:0]};
		lag <= 2'(rnd() % 4);
		ex(1'b0, 1'b0, pb(ent), 16'h0000);
		ex(1'b1, 1'b1, pb(ENT_COMMAND), cw);
		ex(1'b1, 1'b1, a, cw);
		send(0, cw);
		for (int i = 0; i < n; i++) begin
			a = nx(a, x);
			d = 16'(rnd());
			ex(1'b1, 1'b1, a, d);
			send(1, d);
		end
		a = nx(a, x);
		ex(1'b0, 1'b1, a, 16'h0000);
		ex(1'b1, 1'b1, pb(ent), nx(a, x));
		send(2, 16'h0000);
		drain();
	endtask
	task automatic tx_msg(input logic [4:0] sa, input int n);
		logic [15:0] a;
		a = mdl.mem[pb({1'b1, sa})];
		cw = {5'h05, 1'b1, sa, n[4:0]};
		ex(1'b0, 1'b0, pb({1'b1, sa}), 16'h0000);
		ex(1'b1, 1'b1, pb(ENT_COMMAND), cw);
		send(0, cw);
		for (int i = 0; i < n; i++) begin
			ex(1'b0, 1'b0, a + i[15:0], 16'h0000);
			txq.push_back(mdl.mem[a + i[15:0]]);
			send(3, 16'h0000);
		end
		send(2, 16'h0000);
		drain();
	endtask

	// *************************************
	// monitor: each result takes the oldest note
	// *************************************
	always @(posedge pclk) begin
		if (dma_request_out === 1'b1 && dma_grant_in === 1'b1) begin
			e = exq.size() ? exq.pop_front() : 34'h3_ffff_ffff;
			check("mem access", {1'b0, mem_we, mem_addr,
				e[33] ? mem_wdata : e[15:0]}, {1'b0, e[32:0]});
		end
		if (tx_word_valid === 1'b1) begin
			// own variable: the stimulus process also uses d
			e = txq.size() ? {18'h0_0000, txq.pop_front()}
			               : {18'h0_0000, ~tx_word};
			check("tx word", {18'h0_0000, tx_word}, e);
		end
	end

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{cmd_valid, rx_word_valid, msg_end, tx_word_req} = 4'h0;
		{cmd_word, rx_word, lag} = '0;
		base = 10'h010;
		for (int a = 16'h8000; a < 16'hA000; a++)
			mdl.mem[a] = 16'(rnd());
		for (int i = 0; i < 64; i++)
			mdl.mem[{base, i[5:0]}] = 16'h8000 | (i[15:0] << 7);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(OFS_BASE_PTR, {16'h0000, BPR_RESET});
		rdchk(OFS_CONFIG, 32'h0000_0000);
		rdchk(8'h14, 32'h0000_0000);
		apb(1'b1, OFS_BASE_PTR, 32'h0000_ffff);
		rdchk(OFS_BASE_PTR, {16'h0000, BPR_WMASK});
		apb(1'b1, OFS_BASE_PTR, {16'h0000, base, 6'h03});
		apb(1'b1, OFS_CONFIG, 32'h0000_0003);
		// wraps after eight words, then the same subaddress again
		ma[4:0] = 5'd1 + 5'(rnd() % 30);
		rx_msg({1'b0, ma[4:0]}, ma[4:0], 4'h3, 6);
		rx_msg({1'b0, ma[4:0]}, ma[4:0], 4'h3, 2);
		apb(1'b1, OFS_BASE_PTR, {16'h0000, base, 6'h14});
		// inverted subaddress stays in 1..30, never a mode field
		rx_msg(ENT_SINGLE, ~ma[4:0], 4'h4, 3);
		apb(1'b1, OFS_BASE_PTR, {16'h0000, base, 6'h03});
		tx_msg(ma[4:0], 3);
		tx_msg(ma[4:0], 2);
		// mode command with data, receive then transmit-last-command
		ma = mdl.mem[pb(ENT_MODE_DATA)];
		cw = {5'h05, 1'b0, SA_MODE_LO, 5'h11};
		d = 16'(rnd());
		ex(1'b0, 1'b0, pb(ENT_MODE_DATA), 16'h0000);
		ex(1'b1, 1'b1, pb(ENT_COMMAND), cw);
		ex(1'b1, 1'b1, {ma[15:4], 4'h1}, d);
		send(0, cw);
		send(1, d);
		send(2, 16'h0000);
		drain();
		cw = {5'h05, 1'b1, SA_MODE_HI, MC_TX_LAST};
		ex(1'b0, 1'b0, pb(ENT_MODE_DATA), 16'h0000);
		ex(1'b0, 1'b0, {ma[15:4], 4'h2}, 16'h0000);
		txq.push_back(mdl.mem[{ma[15:4], 4'h2}]);
		send(0, cw);
		send(3, 16'h0000);
		send(2, 16'h0000);
		drain();
		// revision A drops data mode codes, keeps the plain ones
		apb(1'b1, OFS_CONFIG, 32'h0000_0001);
		send(0, {5'h05, 1'b0, SA_MODE_LO, 5'h11});
		send(1, 16'h1234);
		send(2, 16'h0000);
		cw = {5'h05, 1'b0, SA_MODE_HI, 5'h02};
		ex(1'b1, 1'b1, pb(ENT_COMMAND), cw);
		send(0, cw);
		send(2, 16'h0000);
		drain();
		// counter still holds the last mode data address, no step
		rdchk(OFS_COUNTER, {16'h0000, ma[15:4], 4'h2});
		// tag ticks once per twenty cycles, so a quick read-back matches
		d = 16'(rnd());
		apb(1'b1, OFS_TIME_TAG, {16'h0000, d});
		rdchk(OFS_TIME_TAG, {16'h0000, d});
		rdchk(OFS_STATUS, 32'h0000_0000);
		results();
	end
endmodule
